//--- pkg/spr_pkg.sv
// Constants, register map and state type for the scratchpad RAM port block
package spr_pkg;

    localparam logic [3:0] REG_TAG_LOW = 4'h0;
    localparam logic [3:0] REG_ERR_CTL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    localparam int ERR_CTL_PE_BIT = 0;
    localparam int STAT_DPERR_BIT = 0;
    localparam int STAT_IPERR_BIT = 1;
    localparam int STAT_DPRES_BIT = 2;
    localparam int STAT_IPRES_BIT = 3;
    localparam int STAT_DBUSY_BIT = 4;
    localparam int STAT_IBUSY_BIT = 5;

    localparam logic [23:0] TAG_LOW_RST = 24'h000000;
    localparam logic ERR_CTL_PE_RST = 1'b0;
    localparam logic [1:0] TAG_CMP_PAD = 2'h0;

    localparam logic [1:0] DOP_LOAD = 2'h0;
    localparam logic [1:0] DOP_STORE = 2'h1;
    localparam logic [1:0] DOP_TAG_READ = 2'h2;
    localparam logic [1:0] DOP_TAG_WRITE = 2'h3;

    localparam logic [1:0] IOP_FETCH = 2'h0;
    localparam logic [1:0] IOP_DATA_WRITE = 2'h1;
    localparam logic [1:0] IOP_TAG_READ = 2'h2;
    localparam logic [1:0] IOP_TAG_WRITE = 2'h3;

    typedef enum logic {
        ST_IDLE,
        ST_ACCESS
    } spr_state_t;

endpackage

//--- rtl/spr_port.sv
// Scratchpad RAM data and instruction port controller
`timescale 1ns/10ps
module spr_port #(
    parameter bit PARITY_IMPL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic core_d_valid,
    input wire logic [1:0] core_d_op,
    input wire logic [19:2] core_d_vindex,
    input wire logic [31:10] core_d_paddr,
    input wire logic [31:0] core_d_wdata,
    input wire logic [3:0] core_d_be,
    input wire logic core_d_lock,
    output logic core_d_ready,
    output logic core_d_done,
    output logic core_d_hit,
    output logic [31:0] core_d_rdata,
    output logic core_d_perr,
    input wire logic core_i_valid,
    input wire logic [1:0] core_i_op,
    input wire logic [19:2] core_i_vindex,
    input wire logic [31:0] core_i_wdata,
    output logic core_i_ready,
    output logic core_i_done,
    output logic core_i_hit,
    output logic [31:0] core_i_rdata,
    output logic core_i_perr,
    output logic [19:2] dport_tag_index,
    output logic dport_tag_read_strobe,
    output logic dport_tag_write_strobe,
    output logic [23:0] dport_tag_compare_bus,
    output logic [19:2] dport_data_index,
    output logic [31:0] dport_write_value,
    output logic dport_data_read_strobe,
    output logic dport_data_write_strobe,
    output logic [3:0] dport_byte_enables,
    output logic dport_lock,
    output logic dport_parity_enable,
    output logic [3:0] dport_write_parity,
    input wire logic [31:0] dport_read_value,
    input wire logic [23:0] dport_tag_read_value,
    input wire logic dport_hit,
    input wire logic dport_stall,
    input wire logic dport_parity_present,
    input wire logic [3:0] dport_read_parity,
    input wire logic dport_present,
    output logic [19:2] iport_index,
    output logic iport_read_strobe,
    output logic iport_tag_write_strobe,
    output logic [31:0] iport_write_compare_value,
    output logic iport_data_write_strobe,
    output logic iport_parity_enable,
    output logic [3:0] iport_write_parity,
    input wire logic [31:0] iport_read_value,
    input wire logic [23:0] iport_tag_read_value,
    input wire logic iport_hit,
    input wire logic iport_stall,
    input wire logic iport_parity_present,
    input wire logic [3:0] iport_read_parity,
    input wire logic iport_present
);

    typedef struct packed {
        spr_pkg::spr_state_t d_st;
        logic d_rdy, d_tagop, d_trd, d_twr, d_drd, d_dwr, d_lock;
        logic [19:2] d_tidx, d_didx;
        logic [23:0] d_cmp;
        logic [31:0] d_wval, d_rdata;
        logic [3:0] d_be, d_wpar;
        logic d_pen, d_done, d_hit, d_perr;
        spr_pkg::spr_state_t i_st;
        logic i_rdy, i_tagop, i_rd, i_twr, i_dwr, i_pen, i_done, i_hit, i_perr;
        logic [19:2] i_idx;
        logic [31:0] i_val, i_rdata;
        logic [3:0] i_wpar;
        logic [23:0] tag_low;
        logic [1:0] perr_sticky;
        logic [31:0] rdata;
    } spr_regs_t;

    localparam spr_regs_t REGS_RST = '{
        d_st: spr_pkg::ST_IDLE,
        i_st: spr_pkg::ST_IDLE,
        d_rdy: 1'b1,
        i_rdy: 1'b1,
        d_pen: spr_pkg::ERR_CTL_PE_RST,
        i_pen: spr_pkg::ERR_CTL_PE_RST,
        tag_low: spr_pkg::TAG_LOW_RST,
        default: '0
    };

    spr_regs_t q;
    spr_regs_t d;

    function automatic logic [3:0] byte_parity(input logic [31:0] value);
        return {^value[31:24], ^value[23:16], ^value[15:8], ^value[7:0]};
    endfunction

    logic d_accept;
    logic i_accept;
    logic d_rd_ok;
    logic i_rd_ok;
    logic d_par_bad;
    logic i_par_bad;
    logic [31:0] status_word;

    always_comb begin
        d_accept = core_d_valid && q.d_rdy;
        i_accept = core_i_valid && q.i_rdy;
        d_rd_ok = q.d_trd && !dport_stall;
        i_rd_ok = q.i_rd && !iport_stall;
        d_par_bad = PARITY_IMPL && q.d_pen && dport_parity_present && q.d_drd
            && (byte_parity(dport_read_value) != dport_read_parity);
        i_par_bad = PARITY_IMPL && q.i_pen && iport_parity_present && !q.i_tagop
            && (byte_parity(iport_read_value) != iport_read_parity);
        status_word = 32'h00000000;
        status_word[spr_pkg::STAT_DPERR_BIT] = q.perr_sticky[0];
        status_word[spr_pkg::STAT_IPERR_BIT] = q.perr_sticky[1];
        status_word[spr_pkg::STAT_DPRES_BIT] = dport_present;
        status_word[spr_pkg::STAT_IPRES_BIT] = iport_present;
        status_word[spr_pkg::STAT_DBUSY_BIT] = !q.d_rdy;
        status_word[spr_pkg::STAT_IBUSY_BIT] = !q.i_rdy;

        d = q;
        d.d_done = 1'b0;
        d.i_done = 1'b0;
        d.rdata = 32'h00000000;

        // Register port
        if (reg_wr) begin
            case (reg_addr)
                spr_pkg::REG_TAG_LOW: d.tag_low = reg_wdata[23:0];
                spr_pkg::REG_ERR_CTL: begin
                    d.d_pen = reg_wdata[spr_pkg::ERR_CTL_PE_BIT];
                    d.i_pen = reg_wdata[spr_pkg::ERR_CTL_PE_BIT];
                end
                spr_pkg::REG_STATUS: d.perr_sticky = q.perr_sticky & ~reg_wdata[1:0];
                default: d.rdata = 32'h00000000;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                spr_pkg::REG_TAG_LOW: d.rdata = {8'h00, q.tag_low};
                spr_pkg::REG_ERR_CTL: d.rdata = {31'h00000000, q.d_pen};
                spr_pkg::REG_STATUS: d.rdata = status_word;
                default: d.rdata = 32'h00000000;
            endcase
        end

        // Data port
        case (q.d_st)
            spr_pkg::ST_IDLE: begin
                if (d_accept) begin
                    d.d_tidx = core_d_vindex;
                    d.d_didx = core_d_vindex;
                    d.d_cmp = (core_d_op == spr_pkg::DOP_TAG_WRITE) ? q.tag_low
                        : {core_d_paddr, spr_pkg::TAG_CMP_PAD};
                    d.d_wval = core_d_wdata;
                    d.d_be = core_d_be;
                    d.d_wpar = PARITY_IMPL ? byte_parity(core_d_wdata) : 4'h0;
                    d.d_lock = dport_present && core_d_lock;
                    d.d_tagop = core_d_op == spr_pkg::DOP_TAG_READ;
                    d.d_trd = dport_present && (core_d_op == spr_pkg::DOP_LOAD
                        || core_d_op == spr_pkg::DOP_TAG_READ);
                    d.d_drd = dport_present && core_d_op == spr_pkg::DOP_LOAD;
                    d.d_dwr = dport_present && core_d_op == spr_pkg::DOP_STORE;
                    d.d_twr = dport_present && core_d_op == spr_pkg::DOP_TAG_WRITE;
                    d.d_st = dport_present ? spr_pkg::ST_ACCESS : spr_pkg::ST_IDLE;
                    d.d_rdy = !dport_present;
                    d.d_done = !dport_present;
                    if (!dport_present) begin
                        d.d_hit = 1'b0;
                        d.d_perr = 1'b0;
                        d.d_rdata = 32'h00000000;
                    end
                end
            end
            spr_pkg::ST_ACCESS: begin
                if (!q.d_trd || d_rd_ok) begin
                    d.d_trd = 1'b0;
                    d.d_drd = 1'b0;
                    d.d_dwr = 1'b0;
                    d.d_twr = 1'b0;
                    d.d_lock = 1'b0;
                    d.d_done = 1'b1;
                    d.d_hit = q.d_trd && dport_hit;
                    d.d_rdata = q.d_drd ? dport_read_value : 32'h00000000;
                    d.d_perr = d_par_bad;
                    if (q.d_tagop) begin
                        d.tag_low = dport_tag_read_value;
                    end
                    d.d_st = spr_pkg::ST_IDLE;
                    d.d_rdy = 1'b1;
                end
            end
            default: begin
                d.d_st = spr_pkg::ST_IDLE;
                d.d_rdy = 1'b1;
            end
        endcase

        // Instruction port
        case (q.i_st)
            spr_pkg::ST_IDLE: begin
                if (i_accept) begin
                    d.i_idx = core_i_vindex;
                    d.i_tagop = core_i_op == spr_pkg::IOP_TAG_READ;
                    d.i_rd = iport_present && (core_i_op == spr_pkg::IOP_FETCH
                        || core_i_op == spr_pkg::IOP_TAG_READ);
                    d.i_dwr = iport_present && core_i_op == spr_pkg::IOP_DATA_WRITE;
                    d.i_twr = iport_present && core_i_op == spr_pkg::IOP_TAG_WRITE;
                    d.i_val = (core_i_op == spr_pkg::IOP_TAG_WRITE)
                        ? {8'h00, q.tag_low} : core_i_wdata;
                    d.i_wpar = PARITY_IMPL ? byte_parity(core_i_wdata) : 4'h0;
                    d.i_st = iport_present ? spr_pkg::ST_ACCESS : spr_pkg::ST_IDLE;
                    d.i_rdy = !iport_present;
                    d.i_done = !iport_present;
                    if (!iport_present) begin
                        d.i_hit = 1'b0;
                        d.i_perr = 1'b0;
                        d.i_rdata = 32'h00000000;
                    end
                end
            end
            spr_pkg::ST_ACCESS: begin
                if (!q.i_rd || i_rd_ok) begin
                    d.i_rd = 1'b0;
                    d.i_dwr = 1'b0;
                    d.i_twr = 1'b0;
                    d.i_done = 1'b1;
                    d.i_hit = q.i_rd && iport_hit;
                    d.i_rdata = q.i_rd ? iport_read_value : 32'h00000000;
                    d.i_perr = q.i_rd && i_par_bad;
                    if (q.i_tagop) begin
                        d.tag_low = iport_tag_read_value;
                    end
                    d.i_st = spr_pkg::ST_IDLE;
                    d.i_rdy = 1'b1;
                end
            end
            default: begin
                d.i_st = spr_pkg::ST_IDLE;
                d.i_rdy = 1'b1;
            end
        endcase

        // Sticky parity errors, set beats clear
        if (d.d_done && d.d_perr) begin
            d.perr_sticky[0] = 1'b1;
        end
        if (d.i_done && d.i_perr) begin
            d.perr_sticky[1] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= REGS_RST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign core_d_ready = q.d_rdy;
    assign core_d_done = q.d_done;
    assign core_d_hit = q.d_hit;
    assign core_d_rdata = q.d_rdata;
    assign core_d_perr = q.d_perr;
    assign core_i_ready = q.i_rdy;
    assign core_i_done = q.i_done;
    assign core_i_hit = q.i_hit;
    assign core_i_rdata = q.i_rdata;
    assign core_i_perr = q.i_perr;
    assign dport_tag_index = q.d_tidx;
    assign dport_tag_read_strobe = q.d_trd;
    assign dport_tag_write_strobe = q.d_twr;
    assign dport_tag_compare_bus = q.d_cmp;
    assign dport_data_index = q.d_didx;
    assign dport_write_value = q.d_wval;
    assign dport_data_read_strobe = q.d_drd;
    assign dport_data_write_strobe = q.d_dwr;
    assign dport_byte_enables = q.d_be;
    assign dport_lock = q.d_lock;
    assign dport_parity_enable = q.d_pen;
    assign dport_write_parity = q.d_wpar;
    assign iport_index = q.i_idx;
    assign iport_read_strobe = q.i_rd;
    assign iport_tag_write_strobe = q.i_twr;
    assign iport_write_compare_value = q.i_val;
    assign iport_data_write_strobe = q.i_dwr;
    assign iport_parity_enable = q.i_pen;
    assign iport_write_parity = q.i_wpar;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_tag_compare_pad: assert property (
        clk_en && d_accept && dport_present && core_d_op == spr_pkg::DOP_LOAD
        |=> dport_tag_read_strobe && dport_data_read_strobe
            && dport_tag_compare_bus == {$past(core_d_paddr), 2'h0})
        else $error("bad load compare bus");

    a_tag_write_value: assert property (
        clk_en && d_accept && dport_present && core_d_op == spr_pkg::DOP_TAG_WRITE
        |=> dport_tag_write_strobe && dport_tag_compare_bus == $past(q.tag_low))
        else $error("bad tag write value");

    a_tag_low_load: assert property (
        clk_en && q.d_st == spr_pkg::ST_ACCESS && q.d_tagop && !dport_stall
        |=> q.tag_low == $past(dport_tag_read_value) && core_d_done)
        else $error("tag-low not loaded");

    a_stall_hold: assert property (
        clk_en && dport_data_read_strobe && dport_stall
        |=> dport_data_read_strobe && $stable(dport_data_index) && !core_d_done)
        else $error("read not held in stall");

    a_write_one_cycle: assert property (
        clk_en && dport_data_write_strobe
        |=> !dport_data_write_strobe && core_d_done ##1 !core_d_done)
        else $error("write strobe too long");

    a_parity_mirror: assert property (
        clk_en && reg_wr && reg_addr == spr_pkg::REG_ERR_CTL
        |=> dport_parity_enable == $past(reg_wdata[0])
            && iport_parity_enable == $past(reg_wdata[0]))
        else $error("parity enable wrong");

    a_parity_ignored: assert property (
        clk_en && dport_data_read_strobe && !dport_stall
            && (!dport_parity_present || !dport_parity_enable)
        |=> !core_d_perr)
        else $error("parity error unexpected");

    a_write_parity: assert property (
        dport_data_write_strobe
        |-> dport_write_parity == (PARITY_IMPL ? byte_parity(dport_write_value) : 4'h0))
        else $error("write parity wrong");

    a_ifetch_result: assert property (
        clk_en && iport_read_strobe && !iport_stall
        |=> core_i_done && core_i_rdata == $past(iport_read_value)
            && core_i_hit == $past(iport_hit) && !iport_read_strobe)
        else $error("fetch result missing");

    a_lock_with_access: assert property (
        dport_lock |-> dport_tag_read_strobe || dport_data_read_strobe
            || dport_data_write_strobe)
        else $error("lock without access");

    c_load_hit: cover property (
        clk_en && dport_data_read_strobe && !dport_stall && dport_hit);
    c_load_stalled: cover property (
        dport_data_read_strobe && dport_stall ##1 dport_data_read_strobe);
    c_both_ports: cover property (dport_tag_read_strobe && iport_read_strobe);
    c_tag_write: cover property (dport_tag_write_strobe || iport_tag_write_strobe);

endmodule

//--- tb/scratchpad_ram_port_tb_top.sv
// Testbench for the scratchpad RAM port block
`timescale 1ns/10ps
module scratchpad_ram_port_tb_top;
    logic sys_clk, rst, clk_en, reg_wr, reg_rd, core_d_valid, core_d_lock, core_i_valid;
    logic [3:0] reg_addr, core_d_be, dport_byte_enables, dport_write_parity, dport_read_parity;
    logic [31:0] reg_wdata, reg_rdata, core_d_wdata, core_d_rdata, core_i_wdata, core_i_rdata;
    logic [1:0] core_d_op, core_i_op;
    logic [19:2] core_d_vindex, core_i_vindex, dport_tag_index, dport_data_index, iport_index;
    logic [31:10] core_d_paddr;
    logic core_d_ready, core_d_done, core_d_hit, core_d_perr, dport_tag_read_strobe;
    logic core_i_ready, core_i_done, core_i_hit, core_i_perr, dport_tag_write_strobe;
    logic dport_data_read_strobe, dport_data_write_strobe, dport_lock, dport_parity_enable;
    logic dport_hit, dport_stall, dport_parity_present, dport_present, iport_read_strobe;
    logic iport_tag_write_strobe, iport_data_write_strobe, iport_parity_enable, iport_hit;
    logic iport_stall, iport_parity_present, iport_present, d_bad, d_held;
    logic [23:0] dport_tag_compare_bus, dport_tag_read_value, iport_tag_read_value, ds_bus;
    logic [31:0] dport_write_value, dport_read_value, iport_write_compare_value;
    logic [31:0] iport_read_value, ds_val, is_val, rd;
    logic [3:0] iport_write_parity, iport_read_parity, ds_be, ds_par, is_par;
    logic [4:0] ds_stb;
    logic [2:0] d_stall, is_stb;
    logic [19:2] ds_ti, ds_di, is_idx;
    int num_errors, n_checks, d_wait, i_wait;

    spr_port u_dut (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .core_d_valid, .core_d_op, .core_d_vindex, .core_d_paddr, .core_d_wdata, .core_d_be,
        .core_d_lock, .core_d_ready, .core_d_done, .core_d_hit, .core_d_rdata, .core_d_perr,
        .core_i_valid, .core_i_op, .core_i_vindex, .core_i_wdata, .core_i_ready, .core_i_done,
        .core_i_hit, .core_i_rdata, .core_i_perr, .dport_tag_index, .dport_tag_read_strobe,
        .dport_tag_write_strobe, .dport_tag_compare_bus, .dport_data_index, .dport_write_value,
        .dport_data_read_strobe, .dport_data_write_strobe, .dport_byte_enables, .dport_lock,
        .dport_parity_enable, .dport_write_parity, .dport_read_value, .dport_tag_read_value,
        .dport_hit, .dport_stall, .dport_parity_present, .dport_read_parity, .dport_present,
        .iport_index, .iport_read_strobe, .iport_tag_write_strobe, .iport_write_compare_value,
        .iport_data_write_strobe, .iport_parity_enable, .iport_write_parity, .iport_read_value,
        .iport_tag_read_value, .iport_hit, .iport_stall, .iport_parity_present,
        .iport_read_parity, .iport_present);
    // Separate array per port
    spr_array_model u_dmem (.sys_clk, .stall_cycles(d_stall), .corrupt_parity(d_bad),
        .tag_index(dport_tag_index), .data_index(dport_data_index),
        .rd_strobe(dport_tag_read_strobe), .data_wr_strobe(dport_data_write_strobe),
        .tag_wr_strobe(dport_tag_write_strobe), .wr_value(dport_write_value),
        .byte_enables(dport_byte_enables), .tag_wr_value(dport_tag_compare_bus),
        .read_value(dport_read_value), .tag_read_value(dport_tag_read_value), .hit(dport_hit),
        .stall(dport_stall), .parity_present(dport_parity_present),
        .read_parity(dport_read_parity));
    spr_array_model u_imem (.sys_clk, .stall_cycles(3'h0), .corrupt_parity(1'b0),
        .tag_index(iport_index), .data_index(iport_index), .rd_strobe(iport_read_strobe),
        .data_wr_strobe(iport_data_write_strobe), .tag_wr_strobe(iport_tag_write_strobe),
        .wr_value(iport_write_compare_value), .byte_enables(4'hF),
        .tag_wr_value(iport_write_compare_value[23:0]), .read_value(iport_read_value),
        .tag_read_value(iport_tag_read_value), .hit(iport_hit), .stall(iport_stall),
        .parity_present(iport_parity_present), .read_parity(iport_read_parity));

    function automatic logic [3:0] par4(input logic [31:0] v);
        return {^v[31:24], ^v[23:16], ^v[15:8], ^v[7:0]};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask
    task automatic dreq(input logic [1:0] op, input logic [19:2] vi, input logic [31:10] pa,
            input logic [31:0] wd, input logic [3:0] be, input logic lk);
        @(posedge sys_clk);
        core_d_valid <= 1'b1;
        core_d_op <= op;
        core_d_vindex <= vi;
        core_d_paddr <= pa;
        core_d_wdata <= wd;
        core_d_be <= be;
        core_d_lock <= lk;
        @(posedge sys_clk);
        core_d_valid <= 1'b0;
        #1;
        ds_stb = {dport_tag_read_strobe, dport_tag_write_strobe, dport_data_read_strobe,
            dport_data_write_strobe, dport_lock};
        ds_bus = dport_tag_compare_bus;
        ds_val = dport_write_value;
        ds_be = dport_byte_enables;
        ds_par = dport_write_parity;
        ds_ti = dport_tag_index;
        ds_di = dport_data_index;
        d_wait = 0;
        d_held = 1'b1;
        while (core_d_done !== 1'b1 && d_wait < 20) begin
            if (dport_tag_index !== vi || dport_tag_read_strobe !== ds_stb[4]) d_held = 1'b0;
            @(posedge sys_clk);
            #1;
            d_wait++;
        end
    endtask
    task automatic ireq(input logic [1:0] op, input logic [19:2] vi, input logic [31:0] wd);
        @(posedge sys_clk);
        core_i_valid <= 1'b1;
        core_i_op <= op;
        core_i_vindex <= vi;
        core_i_wdata <= wd;
        @(posedge sys_clk);
        core_i_valid <= 1'b0;
        #1;
        is_stb = {iport_read_strobe, iport_tag_write_strobe, iport_data_write_strobe};
        is_val = iport_write_compare_value;
        is_par = iport_write_parity;
        is_idx = iport_index;
        i_wait = 0;
        while (core_i_done !== 1'b1 && i_wait < 20) begin
            @(posedge sys_clk);
            #1;
            i_wait++;
        end
    endtask

    task automatic t_regs();
        check("dport pe rst", {31'h0, dport_parity_enable}, 32'h0);
        reg_write(spr_pkg::REG_ERR_CTL, 32'h00000001);
        #1;
        check("dport pe", {31'h0, dport_parity_enable}, 32'h1);
        check("iport pe", {31'h0, iport_parity_enable}, 32'h1);
        reg_read(4'hC);
        check("unmapped", rd, 32'h0);
        reg_read(spr_pkg::REG_STATUS);
        check("status", rd, 32'h0000000C);
    endtask
    task automatic t_store_load();
        dreq(spr_pkg::DOP_STORE, 18'h00005, 22'h0, 32'h11223344, 4'hF, 1'b0);
        check("st strobes", {27'h0, ds_stb}, 32'h2);
        check("st value", ds_val, 32'h11223344);
        check("st latency", d_wait, 1);
        dreq(spr_pkg::DOP_STORE, 18'h00005, 22'h0, 32'hA1B2C3D4, 4'h5, 1'b0);
        check("st be", {28'h0, ds_be}, 32'h5);
        check("st par", {28'h0, ds_par}, {28'h0, par4(32'hA1B2C3D4)});
        dreq(spr_pkg::DOP_LOAD, 18'h00005, 22'h2AAAAA, 32'h0, 4'h0, 1'b1);
        check("ld strobes", {27'h0, ds_stb}, 32'h15);
        check("cmp bus", {8'h0, ds_bus}, 32'h00AAAAA8);
        check("tag idx", {14'h0, ds_ti}, 32'h5);
        check("data idx", {14'h0, ds_di}, 32'h5);
        check("ld data", core_d_rdata, 32'h11B233D4);
        check("ld hit", {31'h0, core_d_hit}, 32'h1);
        check("ld perr", {31'h0, core_d_perr}, 32'h0);
        dreq(spr_pkg::DOP_LOAD, 18'h3FC05, 22'h0, 32'h0, 4'h0, 1'b0);
        check("miss hit", {31'h0, core_d_hit}, 32'h0);
        d_stall = 3'h3;
        dreq(spr_pkg::DOP_LOAD, 18'h00005, 22'h0, 32'h0, 4'h0, 1'b0);
        d_stall = 3'h0;
        check("stall wait", d_wait, 4);
        check("stall hold", {31'h0, d_held}, 32'h1);
        check("stall data", core_d_rdata, 32'h11B233D4);
    endtask
    task automatic t_tags();
        reg_write(spr_pkg::REG_TAG_LOW, 32'h00ABCD03);
        dreq(spr_pkg::DOP_TAG_WRITE, 18'h00001, 22'h0, 32'h0, 4'h0, 1'b0);
        check("tw strobes", {27'h0, ds_stb}, 32'h8);
        check("tw bus", {8'h0, ds_bus}, 32'h00ABCD03);
        reg_write(spr_pkg::REG_TAG_LOW, 32'h00123401);
        dreq(spr_pkg::DOP_TAG_READ, 18'h00001, 22'h0, 32'h0, 4'h0, 1'b0);
        check("tr strobes", {27'h0, ds_stb}, 32'h10);
        reg_read(spr_pkg::REG_TAG_LOW);
        check("tag low", rd, 32'h00ABCD03);
    endtask
    task automatic t_parity();
        d_bad = 1'b1;
        dreq(spr_pkg::DOP_LOAD, 18'h00005, 22'h0, 32'h0, 4'h0, 1'b0);
        check("perr on", {31'h0, core_d_perr}, 32'h1);
        reg_write(spr_pkg::REG_ERR_CTL, 32'h0);
        dreq(spr_pkg::DOP_LOAD, 18'h00005, 22'h0, 32'h0, 4'h0, 1'b0);
        check("perr off", {31'h0, core_d_perr}, 32'h0);
        d_bad = 1'b0;
    endtask
    task automatic t_iport();
        ireq(spr_pkg::IOP_DATA_WRITE, 18'h00003, 32'hCAFE0001);
        check("iw strobes", {29'h0, is_stb}, 32'h1);
        check("iw value", is_val, 32'hCAFE0001);
        check("iw idx", {14'h0, is_idx}, 32'h3);
        check("iw par", {28'h0, is_par}, {28'h0, par4(32'hCAFE0001)});
        ireq(spr_pkg::IOP_FETCH, 18'h00003, 32'h0);
        check("if strobes", {29'h0, is_stb}, 32'h4);
        check("if data", core_i_rdata, 32'hCAFE0001);
        check("if hit", {31'h0, core_i_hit}, 32'h1);
        ireq(spr_pkg::IOP_TAG_WRITE, 18'h00003, 32'h0);
        check("it strobes", {29'h0, is_stb}, 32'h2);
        check("it value", is_val, 32'h00ABCD03);
        d_stall = 3'h2;
        fork
            dreq(spr_pkg::DOP_LOAD, 18'h00005, 22'h0, 32'h0, 4'h0, 1'b0);
            ireq(spr_pkg::IOP_FETCH, 18'h00003, 32'h0);
        join
        d_stall = 3'h0;
        check("indep i", i_wait, 1);
        check("indep d", d_wait, 3);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        {rst, clk_en, reg_wr, reg_rd, core_d_valid, core_d_lock, core_i_valid} = 7'h60;
        {reg_addr, reg_wdata, core_d_op, core_d_vindex, core_d_paddr} = '0;
        {core_d_wdata, core_d_be, core_i_op, core_i_vindex, core_i_wdata} = '0;
        {dport_present, iport_present, d_bad, d_stall} = 6'h30;
        num_errors = 0;
        n_checks = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        t_regs();
        t_store_load();
        t_tags();
        t_parity();
        t_iport();
        report_and_stop();
    end
endmodule

//--- tb/spr_array_model.sv
// Behavioural scratchpad array with tag store for one port
`timescale 1ns/10ps
module spr_array_model (
    input wire logic sys_clk,
    input wire logic [2:0] stall_cycles,
    input wire logic corrupt_parity,
    input wire logic [19:2] tag_index,
    input wire logic [19:2] data_index,
    input wire logic rd_strobe,
    input wire logic data_wr_strobe,
    input wire logic tag_wr_strobe,
    input wire logic [31:0] wr_value,
    input wire logic [3:0] byte_enables,
    input wire logic [23:0] tag_wr_value,
    output logic [31:0] read_value,
    output logic [23:0] tag_read_value,
    output logic hit,
    output logic stall,
    output logic parity_present,
    output logic [3:0] read_parity
);
    logic [31:0] mem_q [16];
    logic [23:0] tag_q;
    logic [31:0] last_q;
    logic [2:0] wait_q;
    logic ready;
    initial begin
        tag_q = 24'h000000;
        last_q = 32'h00000000;
        wait_q = 3'h0;
        for (int i = 0; i < 16; i++) mem_q[i] = 32'h00000000;
    end
    assign ready = rd_strobe && (wait_q >= stall_cycles);
    assign stall = rd_strobe && !ready;
    assign hit = ready && (tag_index[19:12] == 8'h00);
    assign read_value = ready ? mem_q[data_index[5:2]] : ~last_q;
    assign tag_read_value = ready ? tag_q : ~tag_q;
    assign parity_present = 1'b1;
    assign read_parity = {^read_value[31:24], ^read_value[23:16], ^read_value[15:8],
        ^read_value[7:0]} ^ {4{corrupt_parity}};
    always @(posedge sys_clk) begin
        wait_q <= (rd_strobe && !ready) ? wait_q + 3'h1 : 3'h0;
        if (ready) last_q <= mem_q[data_index[5:2]];
        if (tag_wr_strobe) tag_q <= tag_wr_value;
        for (int b = 0; b < 4; b++) begin
            if (data_wr_strobe && byte_enables[b])
                mem_q[data_index[5:2]][b*8 +: 8] <= wr_value[b*8 +: 8];
        end
    end
endmodule
